// [core/rcrc_top.sv]
// Purpose: Clock reference control: RC oscillators, crystal trim pair, external oscillator mode
// Assumes: APB slave, 32-bit data, word per register, byte address = 4 * index
// Notes:   External oscillator mode is left only by reset
// Contract
// - Fast RC oscillator runs whenever the host bus is active.
// - Slow RC oscillator runs during sleep and while the amplifier ramp is busy.
// - Two independent trim registers, one per crystal pin, 0.47 pF per code.
// - Code zero means 11.3 pF; code 0x2F means 33.4 pF.
// - Reset and cold wake from sleep load both trims with 0x05.
// - Entering crystal standby overwrites both trims with 0x12.
// - External oscillator supply command sets pin A trim to 0x2F.
// - External oscillator mode drives line three supply outside sleep, 1.6 to 3.3 V.
// - External oscillator mode holds until a full chip reset.
// - Transmit power settable over 31 steps down from maximum.
// - Amplifier ramp time selectable from 10 to 3400 microseconds.
`timescale 1ns/100ps
`default_nettype none
`include "rcrc_cfg.svh"
module rcrc_top
  import rcrc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_start,
  output logic             fast_rc_osc_on,
  output logic             slow_rc_osc_on,
  output logic             slow_rc_tick,
  output logic [15:0]      crystal_pin_a_cap_ff,
  output logic [15:0]      crystal_pin_b_cap_ff,
  output logic             io_line_three_en,
  output logic [11:0]      io_line_three_mv,
  output logic [4:0]       tx_power_range,
  output logic [11:0]      pa_ramp_time,
  output logic             pa_ramp_busy
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic [15:0] idx;
  logic        wr_en;
  logic        rd_en;
  logic        hit;

  assign idx    = paddr[17:2];
  assign wr_en  = ce && psel && penable && pwrite;
  assign rd_en  = ce && psel && penable && !pwrite;
  assign pready = 1'b1;

  function automatic logic is_mapped(input logic [15:0] i);
    if (i == `RCRC_IDX_TRIM_A) begin
      is_mapped = 1'b1;
    end else if (i == `RCRC_IDX_TRIM_B) begin
      is_mapped = 1'b1;
    end else if (i >= `RCRC_IDX_MODE && i <= `RCRC_IDX_STATUS) begin
      is_mapped = 1'b1;
    end else begin
      is_mapped = 1'b0;
    end
  endfunction

  assign hit     = is_mapped(idx);
  assign pslverr = psel && penable && !hit;

  function automatic logic [15:0] cap_ff(input rcrc_trim_t code);
    cap_ff = 16'(`RCRC_CAP_MIN_FF + code * `RCRC_CAP_STEP_FF);
  endfunction

  function automatic rcrc_trim_t trim_clip(input logic [7:0] v);
    trim_clip = (v > `RCRC_TRIM_MAX) ? `RCRC_TRIM_MAX : v;
  endfunction

  // ------------------------------------------------------------
  // Commands and mode
  // ------------------------------------------------------------
  logic       cmd_wr;
  logic [7:0] cmd_code;
  rcrc_mode_t mode_r;
  rcrc_mode_t mode_nxt;
  logic       xosc_entry;
  logic       cold_wake;
  logic       tcxo_cmd;
  logic       tcxo_mode_r;

  assign cmd_wr     = wr_en && idx == `RCRC_IDX_CMD;
  assign cmd_code   = pwdata[7:0];
  assign tcxo_cmd   = cmd_wr && cmd_code == `RCRC_CMD_TCXO;
  assign xosc_entry = (mode_r != RCRC_MODE_XOSC) && (mode_nxt == RCRC_MODE_XOSC);
  assign cold_wake  = (mode_r == RCRC_MODE_SLEEP) && (mode_nxt != RCRC_MODE_SLEEP);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      RCRC_MODE_RC: begin
        if (cmd_wr && cmd_code == `RCRC_CMD_XOSC) begin
          mode_nxt = RCRC_MODE_XOSC;
        end else if (cmd_wr && cmd_code == `RCRC_CMD_SLEEP_COLD) begin
          mode_nxt = RCRC_MODE_SLEEP;
        end
      end
      RCRC_MODE_XOSC: begin
        if (cmd_wr && cmd_code == `RCRC_CMD_STDBY_RC) begin
          mode_nxt = RCRC_MODE_RC;
        end else if (cmd_wr && cmd_code == `RCRC_CMD_SLEEP_COLD) begin
          mode_nxt = RCRC_MODE_SLEEP;
        end
      end
      RCRC_MODE_SLEEP: begin
        // Any bus access wakes the device; the fast RC restarts with it
        if (psel) begin
          mode_nxt = RCRC_MODE_RC;
        end
      end
      default: begin
        mode_nxt = RCRC_MODE_RC;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= RCRC_MODE_RC;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  // Sticky: only reset clears it, no command leaves this mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tcxo_mode_r <= 1'b0;
    end else if (ce && tcxo_cmd) begin
      tcxo_mode_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Trim capacitor pair
  // ------------------------------------------------------------
  rcrc_trim_t trim_a_r;
  rcrc_trim_t trim_b_r;

  // Hardware loads win over a host write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_a_r <= `RCRC_TRIM_RESET;
    end else if (ce) begin
      if (tcxo_cmd) begin
        trim_a_r <= `RCRC_TRIM_MAX;
      end else if (xosc_entry) begin
        trim_a_r <= `RCRC_TRIM_XOSC;
      end else if (cold_wake) begin
        trim_a_r <= `RCRC_TRIM_RESET;
      end else if (wr_en && idx == `RCRC_IDX_TRIM_A) begin
        trim_a_r <= trim_clip(pwdata[7:0]);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_b_r <= `RCRC_TRIM_RESET;
    end else if (ce) begin
      if (xosc_entry) begin
        trim_b_r <= `RCRC_TRIM_XOSC;
      end else if (cold_wake) begin
        trim_b_r <= `RCRC_TRIM_RESET;
      end else if (wr_en && idx == `RCRC_IDX_TRIM_B) begin
        trim_b_r <= trim_clip(pwdata[7:0]);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      crystal_pin_a_cap_ff <= `RCRC_CAP_MIN_FF;
      crystal_pin_b_cap_ff <= `RCRC_CAP_MIN_FF;
    end else if (ce) begin
      crystal_pin_a_cap_ff <= cap_ff(trim_a_r);
      crystal_pin_b_cap_ff <= cap_ff(trim_b_r);
    end
  end

  // ------------------------------------------------------------
  // Transmit power, ramp and line three supply
  // ------------------------------------------------------------
  logic [11:0] volt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_power_range <= '0;
    end else if (ce && wr_en && idx == `RCRC_IDX_TX_POWER) begin
      // Step 0 is full power, step 31 is 31 dB below it
      tx_power_range <= (pwdata > 32'(`RCRC_PWR_STEPS)) ?
                        `RCRC_PWR_STEPS : pwdata[4:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pa_ramp_time <= `RCRC_RAMP_MIN_US;
    end else if (ce && wr_en && idx == `RCRC_IDX_RAMP) begin
      if (pwdata[11:0] < `RCRC_RAMP_MIN_US || pwdata[31:12] != '0) begin
        pa_ramp_time <= (pwdata[31:12] != '0) ? `RCRC_RAMP_MAX_US : `RCRC_RAMP_MIN_US;
      end else if (pwdata[11:0] > `RCRC_RAMP_MAX_US) begin
        pa_ramp_time <= `RCRC_RAMP_MAX_US;
      end else begin
        pa_ramp_time <= pwdata[11:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      volt_r <= `RCRC_VOLT_MIN_MV;
    end else if (ce && tcxo_cmd) begin
      // Voltage travels with the command, in pwdata[27:16], in millivolts
      if (pwdata[27:16] < `RCRC_VOLT_MIN_MV) begin
        volt_r <= `RCRC_VOLT_MIN_MV;
      end else if (pwdata[27:16] > `RCRC_VOLT_MAX_MV) begin
        volt_r <= `RCRC_VOLT_MAX_MV;
      end else begin
        volt_r <= pwdata[27:16];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_line_three_en <= 1'b0;
      io_line_three_mv <= '0;
    end else if (ce) begin
      io_line_three_en <= tcxo_mode_r && (mode_r != RCRC_MODE_SLEEP);
      io_line_three_mv <= tcxo_mode_r ? volt_r : 12'h000;
    end
  end

  rcrc_ramp_timer #(
    .CNT_W (16)
  ) u_ramp (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .start   (tx_start),
    .ramp_us (pa_ramp_time),
    .busy    (pa_ramp_busy)
  );

  // ------------------------------------------------------------
  // RC oscillators
  // ------------------------------------------------------------
  // Fast RC never depends on the crystal, so the bus works straight after reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fast_rc_osc_on <= 1'b1;
      slow_rc_osc_on <= 1'b0;
    end else if (ce) begin
      fast_rc_osc_on <= (mode_nxt != RCRC_MODE_SLEEP) || psel;
      slow_rc_osc_on <= (mode_nxt == RCRC_MODE_SLEEP) || pa_ramp_busy;
    end
  end

  rcrc_osc_tick #(
    .DIV_W (8)
  ) u_slow (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ce      (ce),
    .run     (slow_rc_osc_on),
    .div     (`RCRC_SLOW_DIV),
    .tick    (slow_rc_tick)
  );

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (ce && psel && !penable && !pwrite) begin
      if (idx == `RCRC_IDX_TRIM_A) begin
        prdata <= {24'h000000, trim_a_r};
      end else if (idx == `RCRC_IDX_TRIM_B) begin
        prdata <= {24'h000000, trim_b_r};
      end else if (idx == `RCRC_IDX_MODE) begin
        prdata <= {30'h00000000, mode_r};
      end else if (idx == `RCRC_IDX_TX_POWER) begin
        prdata <= {27'h0000000, tx_power_range};
      end else if (idx == `RCRC_IDX_RAMP) begin
        prdata <= {20'h00000, pa_ramp_time};
      end else if (idx == `RCRC_IDX_TCXO_VOLT) begin
        prdata <= {20'h00000, volt_r};
      end else if (idx == `RCRC_IDX_STATUS) begin
        prdata <= {28'h0000000, pa_ramp_busy, slow_rc_osc_on, fast_rc_osc_on, tcxo_mode_r};
      end else begin
        prdata <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// [common/rcrc_cfg.svh]
// Purpose: Register offsets, reset values and timing counts for the clock reference control
// Assumes: 10 MHz system clock
// Notes:   Offsets of the trim pair are register indices; byte address is four times the index
`ifndef RCRC_CFG_SVH
`define RCRC_CFG_SVH

`define RCRC_IDX_TRIM_A      16'h0911
`define RCRC_IDX_TRIM_B      16'h0912
`define RCRC_IDX_MODE        16'h0a00
`define RCRC_IDX_CMD         16'h0a01
`define RCRC_IDX_TX_POWER    16'h0a02
`define RCRC_IDX_RAMP        16'h0a03
`define RCRC_IDX_TCXO_VOLT   16'h0a04
`define RCRC_IDX_STATUS      16'h0a05

`define RCRC_TRIM_RESET      8'h05
`define RCRC_TRIM_XOSC       8'h12
`define RCRC_TRIM_MAX        8'h2f
`define RCRC_TRIM_W          8

`define RCRC_CAP_MIN_FF      16'd11300
`define RCRC_CAP_STEP_FF     16'd470

`define RCRC_PWR_STEPS       5'd31
`define RCRC_RAMP_MIN_US     12'd10
`define RCRC_RAMP_MAX_US     12'd3400

`define RCRC_VOLT_MIN_MV     12'd1600
`define RCRC_VOLT_MAX_MV     12'd3300

`define RCRC_CLK_MHZ         10
`define RCRC_RAMP_CYC_PER_US 10

`define RCRC_FAST_DIV        4'd1
`define RCRC_SLOW_DIV        8'd156

`define RCRC_CMD_XOSC        8'h01
`define RCRC_CMD_TCXO        8'h02
`define RCRC_CMD_SLEEP_COLD  8'h03
`define RCRC_CMD_STDBY_RC    8'h04

`endif

// [common/rcrc_pkg.sv]
// Purpose: Types for the clock reference control
// Assumes: Constants live in rcrc_cfg.svh
// Notes:   Mode order is not significant
package rcrc_pkg;
  typedef enum logic [1:0] {
    RCRC_MODE_RC,
    RCRC_MODE_XOSC,
    RCRC_MODE_SLEEP
  } rcrc_mode_t;
  typedef logic [7:0] rcrc_trim_t;
endpackage

// [core/rcrc_osc_tick.sv]
// Purpose: Tick generator standing in for an RC oscillator timebase
// Assumes: Enable gates counting
// Notes:   Divider width fixed by parameter
`timescale 1ns/100ps
`default_nettype none
module rcrc_osc_tick
  import rcrc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             ce,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= '0;
        tick  <= 1'b0;
      end else if (cnt_r >= div) begin
        cnt_r <= '0;
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
        tick  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/rcrc_ramp_timer.sv]
// Purpose: Power amplifier ramp timer
// Assumes: Ramp time given in microseconds, already clamped
// Notes:   Counts system cycles; busy while ramping
`timescale 1ns/100ps
`default_nettype none
`include "rcrc_cfg.svh"
module rcrc_ramp_timer
  import rcrc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [11:0] ramp_us,
  output logic             busy
);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      busy  <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt_r <= CNT_W'(ramp_us * `RCRC_RAMP_CYC_PER_US);
        busy  <= 1'b1;
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        cnt_r <= '0;
        busy  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/rcrc_top_properties.sv]
// Purpose: Port checks for rcrc_top
// Assumes: One clock, reset_n async active low
// Notes:   Bound below; sees ports only
`timescale 1ns/100ps
`default_nettype none
module rcrc_top_properties (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        tx_start,
  input wire logic        fast_rc_osc_on,
  input wire logic        slow_rc_osc_on,
  input wire logic        slow_rc_tick,
  input wire logic [15:0] crystal_pin_a_cap_ff,
  input wire logic [15:0] crystal_pin_b_cap_ff,
  input wire logic [11:0] io_line_three_mv,
  input wire logic [4:0]  tx_power_range,
  input wire logic [11:0] pa_ramp_time,
  input wire logic        pa_ramp_busy
);
  // ------------------------------
  // Checks
  // ------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic acc_wr;
  assign acc_wr = psel && penable && pwrite && ce;
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access not answered");
  AST_FAST_ON: assert property (psel && ce |=> fast_rc_osc_on)
    else $error("fast osc off during bus access");
  AST_SLOW_TICK: assert property (slow_rc_tick |-> slow_rc_osc_on)
    else $error("slow tick without slow osc");
  AST_CAP_A: assert property ((crystal_pin_a_cap_ff - 16'h2c24) % 16'h01d6 == 16'h0000
    && crystal_pin_a_cap_ff >= 16'h2c24 && crystal_pin_a_cap_ff <= 16'h826e)
    else $error("pin a cap off grid");
  AST_CAP_B: assert property ((crystal_pin_b_cap_ff - 16'h2c24) % 16'h01d6 == 16'h0000
    && crystal_pin_b_cap_ff >= 16'h2c24 && crystal_pin_b_cap_ff <= 16'h826e)
    else $error("pin b cap off grid");
  AST_TCXO_TRIM: assert property (acc_wr && paddr == 18'h02804 && pwdata[7:0] == 8'h02
    |=> ##1 crystal_pin_a_cap_ff == 16'h826e) else $error("pin a cap not at max");
  AST_MV_RANGE: assert property (io_line_three_mv == 12'h000
    || (io_line_three_mv >= 12'h640 && io_line_three_mv <= 12'hce4))
    else $error("supply voltage out of range");
  AST_MV_STICKY: assert property (io_line_three_mv != 12'h000 |=> io_line_three_mv != 12'h000)
    else $error("ext osc supply dropped");
  AST_PWR_CLIP: assert property (acc_wr && paddr == 18'h02808 && pwdata > 32'h1f
    |=> ##[0:1] tx_power_range == 5'h1f) else $error("power not clipped");
  AST_RAMP_RANGE: assert property (pa_ramp_time >= 12'h00a && pa_ramp_time <= 12'hd48)
    else $error("ramp time out of range");
  AST_RAMP_START: assert property (tx_start && ce |=> pa_ramp_busy)
    else $error("ramp not started");
  AST_RAMP_HOLD: assert property ($rose(pa_ramp_busy) |-> pa_ramp_busy[*8])
    else $error("ramp ended too soon");
endmodule
bind rcrc_top rcrc_top_properties rcrc_top_properties_i (.clk_sys, .reset_n, .ce, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .tx_start, .fast_rc_osc_on, .slow_rc_osc_on,
  .slow_rc_tick, .crystal_pin_a_cap_ff, .crystal_pin_b_cap_ff, .io_line_three_mv,
  .tx_power_range, .pa_ramp_time, .pa_ramp_busy);
`default_nettype wire

// [verification/rcrc_host_model.sv]
// Purpose: Host bus master model
// Assumes: Called right after a clock edge
// Notes:   Released address and data lines show inverted values
`timescale 1ns/100ps
`default_nettype none
module rcrc_host_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [17:0]      paddr,
  output logic [31:0]      pwdata
);
  // ------------------------------
  // Transfer
  // ------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h3ffff;
    pwdata = 32'hffffffff;
  end
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pready && n < 16);
    if (!pready) begin
      tb.error_cnt++;
      tb.summarize();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for rcrc_top
// Assumes: Host model drives the bus
// Notes:   Read results checked by a monitor
`timescale 1ns/100ps
`default_nettype none
`include "rcrc_cfg.svh"
module tb;
  import rcrc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic        tx_start = 1'b0;
  wire         psel, penable, pwrite;
  wire  [17:0] paddr;
  wire  [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready, pslverr, fast_on, slow_on, slow_tick, io_en, busy;
  logic [15:0] cap_a, cap_b;
  logic [11:0] mv, ramp;
  logic [4:0]  pwr;
  logic [31:0] exp_q[$];
  logic        exp_err = 1'b0;
  int          error_cnt = 0;
  int          total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  rcrc_host_model rcrc_host_model_i (.clk_sys, .prdata, .pready, .psel, .penable, .pwrite,
    .paddr, .pwdata);
  rcrc_top rcrc_top_i (.clk_sys, .reset_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_start, .fast_rc_osc_on(fast_on), .slow_rc_osc_on(slow_on),
    .slow_rc_tick(slow_tick), .crystal_pin_a_cap_ff(cap_a), .crystal_pin_b_cap_ff(cap_b),
    .io_line_three_en(io_en), .io_line_three_mv(mv), .tx_power_range(pwr),
    .pa_ramp_time(ramp), .pa_ramp_busy(busy));
  // ------------------------------
  // Checking
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      chk("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
    end
    if (psel && penable && pready && !pwrite) begin
      chk("prdata", exp_q.pop_front(), prdata);
    end
  end
  function automatic logic [31:0] fF(input int c);
    return 32'(11300 + c * 470);
  endfunction
  task automatic wr(input int idx, input logic [31:0] d);
    logic [31:0] q;
    rcrc_host_model_i.xfer(1'b1, 18'(idx * 4), d, q);
  endtask
  task automatic rd(input int idx, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    rcrc_host_model_i.xfer(1'b0, 18'(idx * 4), 32'h0, q);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    int r, b, n, v;
    r = $urandom(32'hdce638df);
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`RCRC_IDX_TRIM_A, 32'h05);
    rd(`RCRC_IDX_TRIM_B, 32'h05);
    b = $urandom_range(47);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? $urandom_range(47) : (i == 1) ? 0 : (i == 2) ? 47 : 255;
      wr(`RCRC_IDX_TRIM_A, r);
      wr(`RCRC_IDX_TRIM_B, b);
      r = (r > 47) ? 47 : r;
      rd(`RCRC_IDX_TRIM_A, r);
      rd(`RCRC_IDX_TRIM_B, b);
      #1;
      chk("cap_a", fF(r), cap_a);
      chk("cap_b", fF(b), cap_b);
    end
    // Clock enable low must freeze trim B against a host write
    ce <= 1'b0;
    wr(`RCRC_IDX_TRIM_B, 32'h2a);
    ce <= 1'b1;
    rd(`RCRC_IDX_TRIM_B, b);
    wr(`RCRC_IDX_CMD, 32'h01);
    rd(`RCRC_IDX_TRIM_A, 32'h12);
    rd(`RCRC_IDX_TRIM_B, 32'h12);
    wr(`RCRC_IDX_TRIM_B, 32'h20);
    rd(`RCRC_IDX_TRIM_B, 32'h20);
    wr(`RCRC_IDX_CMD, 32'h03);
    repeat (3) @(posedge clk_sys);
    #1;
    chk("fast_on", 32'h0, fast_on);
    n = 0;
    while (slow_tick !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("slow_tick", 32'h1, slow_tick);
    wr(`RCRC_IDX_TX_POWER, 32'h0);
    rd(`RCRC_IDX_TRIM_A, 32'h05);
    rd(`RCRC_IDX_TRIM_B, 32'h05);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 0 : (i == 1) ? $urandom_range(31) : (i == 2) ? 31 : 40;
      wr(`RCRC_IDX_TX_POWER, r);
      rd(`RCRC_IDX_TX_POWER, (r > 31) ? 31 : r);
      chk("power", (r > 31) ? 31 : r, pwr);
    end
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 9 : (i == 1) ? 3400 : 5000;
      wr(`RCRC_IDX_RAMP, r);
      rd(`RCRC_IDX_RAMP, (i == 0) ? 10 : 3400);
    end
    r = $urandom_range(30, 10);
    wr(`RCRC_IDX_RAMP, r);
    @(posedge clk_sys);
    tx_start <= 1'b1;
    @(posedge clk_sys);
    tx_start <= 1'b0;
    n = 0;
    repeat (400) begin
      #1;
      n += busy;
      @(posedge clk_sys);
    end
    chk("ramp_cycles", r * 10, n);
    v = $urandom_range(3300, 1600);
    wr(`RCRC_IDX_CMD, {4'h0, 12'(v), 16'h0002});
    rd(`RCRC_IDX_TRIM_A, 32'h2f);
    rd(`RCRC_IDX_TCXO_VOLT, v);
    wr(`RCRC_IDX_CMD, 32'h04);
    wr(`RCRC_IDX_CMD, 32'h01);
    exp_err <= 1'b1;
    rd(16'h0913, 32'h0);
    exp_err <= 1'b0;
    #1;
    chk("mv", v, mv);
    chk("io_en", 32'h1, io_en);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("mv_after_reset", 32'h0, mv);
    summarize();
  end
endmodule
`default_nettype wire
